// ---- shared/bvsr_pkg.sv ----
// Constants for the two buck voltage/mode setting registers.
// Assumes a single 25 MHz register clock shared with the control logic.
package bvsr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 6;
  localparam int MV_W = 11;
  localparam int CNT_W = 17;
  localparam int NUM_BUCK = 2;
  // Register map
  localparam logic [ADDR_W-1:0] BUCK1_ADDR = 8'h16;
  localparam logic [ADDR_W-1:0] BUCK2_ADDR = 8'h17;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h99;
  // Field layout
  localparam int PFM_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int CODE_MSB = 5;
  localparam logic PFM_RESET = 1'h1;
  localparam logic [CODE_W-1:0] CODE_RESET = 6'h19;
  // Code table: 10 mV steps up to the knee, 25 mV steps above
  localparam logic [CODE_W-1:0] CODE_KNEE = 6'h32;
  localparam logic [MV_W-1:0] MV_BASE = 11'h352;
  localparam logic [MV_W-1:0] MV_KNEE = 11'h546;
  localparam logic [MV_W-1:0] MV_STEP_FINE = 11'h00a;
  localparam logic [MV_W-1:0] MV_STEP_COARSE = 11'h019;
  // Monitor blanking after a write
  localparam int CLK_HZ = 25000000;
  localparam int BLANK_MS = 5;
  localparam int BLANK_CYC = BLANK_MS * (CLK_HZ / 1000);
endpackage

// ---- verilog/bvsr_blank_timer.sv ----
// Retriggerable blanking timer for one converter's voltage monitors.
// Assumes start_i is a one-cycle pulse on the register clock.
`timescale 1ns/1ps
module bvsr_blank_timer #(
  parameter int CYCLES = bvsr_pkg::BLANK_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  output logic blank_o
);
  logic [bvsr_pkg::CNT_W-1:0] cnt_r;
  logic [bvsr_pkg::CNT_W-1:0] cnt_nxt;

  // Restart wins over countdown so back-to-back writes extend the window
  always_comb begin
    cnt_nxt = cnt_r;
    if (start_i) begin
      cnt_nxt = bvsr_pkg::CNT_W'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign blank_o = (cnt_r != '0);
endmodule

// ---- verilog/bvsr_regs.sv ----
// Voltage/mode setting registers for the first two buck converters.
// Assumes unlock, go and load strobes come from logic on the same clock.
//
// How it works
// RL1: First register at 0x16, resets to 0x99.
// RL2: Second register at 0x17, same layout, 0x99.
// RL3: Writes accepted only after password unlock.
// RL4: Any accepted write blanks that converter's monitors 5 ms.
// RL5: New code applies on go or go-disable.
// RL6: Bit7 pulse-skip enable, bit6 reserved reads zero.
// RL7: Code 19h reset, 0h-32h 10 mV steps.
// RL8: Codes 33h-3Fh 25 mV steps, both converters.
// RL9: Shadow code copied on go; nonvolatile default load.
`timescale 1ns/1ps
module bvsr_regs #(
  parameter int BLANK_CYCLES = bvsr_pkg::BLANK_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [bvsr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [bvsr_pkg::DATA_W-1:0] wdata_i,
  input wire logic unlock_i,
  input wire logic go_i,
  input wire logic apply_with_disable_bit_i,
  input wire logic nv_load_i,
  input wire logic [bvsr_pkg::CODE_W-1:0] nv_code_one_i,
  input wire logic [bvsr_pkg::CODE_W-1:0] nv_code_two_i,
  output logic [bvsr_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic wr_rejected_o,
  output logic apply_disable_o,
  output logic [bvsr_pkg::CODE_W-1:0] buck_converter_one_code_o,
  output logic [bvsr_pkg::CODE_W-1:0] buck_converter_two_code_o,
  output logic [bvsr_pkg::MV_W-1:0] buck_converter_one_mv_o,
  output logic [bvsr_pkg::MV_W-1:0] buck_converter_two_mv_o,
  output logic buck_converter_one_pfm_o,
  output logic buck_converter_two_pfm_o,
  output logic buck_converter_one_blank_o,
  output logic buck_converter_two_blank_o
);
  localparam int N = bvsr_pkg::NUM_BUCK;

  // Code to millivolts, two-slope table
  function automatic logic [bvsr_pkg::MV_W-1:0] code_to_mv(
    input logic [bvsr_pkg::CODE_W-1:0] code
  );
    logic [bvsr_pkg::MV_W-1:0] wide;
    wide = bvsr_pkg::MV_W'(code);
    if (code <= bvsr_pkg::CODE_KNEE) begin
      code_to_mv = bvsr_pkg::MV_BASE + bvsr_pkg::MV_W'(wide * bvsr_pkg::MV_STEP_FINE); // RL7
    end else begin
      code_to_mv = bvsr_pkg::MV_KNEE + bvsr_pkg::MV_W'( // RL8
        (wide - bvsr_pkg::MV_W'(bvsr_pkg::CODE_KNEE)) * bvsr_pkg::MV_STEP_COARSE);
    end
  endfunction

  // Address decode: hit flag and converter index
  function automatic logic [1:0] decode(input logic [bvsr_pkg::ADDR_W-1:0] a);
    decode = 2'h0;
    if (a == bvsr_pkg::BUCK1_ADDR) begin
      decode = 2'h2; // RL1
    end else if (a == bvsr_pkg::BUCK2_ADDR) begin
      decode = 2'h3; // RL2
    end
  endfunction

  // Millivolts of the reset code, fixed at elaboration
  localparam logic [bvsr_pkg::MV_W-1:0] MV_RESET = code_to_mv(bvsr_pkg::CODE_RESET);

  // Register image as the host sees it
  logic [N-1:0] pfm_r;
  logic [N-1:0] pfm_nxt;
  logic [bvsr_pkg::CODE_W-1:0] shadow_r [N];
  logic [bvsr_pkg::CODE_W-1:0] shadow_nxt [N];
  logic rej_r;
  logic rej_nxt;
  // Settings the converters run on
  logic [bvsr_pkg::CODE_W-1:0] active_r [N];
  logic [bvsr_pkg::CODE_W-1:0] active_nxt [N];
  logic [bvsr_pkg::MV_W-1:0] mv_r [N];
  logic [bvsr_pkg::MV_W-1:0] mv_nxt [N];
  logic adis_r;
  logic adis_nxt;
  // Read port
  logic [bvsr_pkg::DATA_W-1:0] rdata_r;
  logic [bvsr_pkg::DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  // Decode and strobes
  logic [N-1:0] blank_start;
  logic [1:0] wdec;
  logic [1:0] rdec;
  logic wr_hit;
  logic wr_ok;
  logic wr_idx;
  logic rd_idx;
  logic apply_any;
  logic [bvsr_pkg::CODE_W-1:0] nv_code [N];

  assign wdec = decode(addr_i);
  assign rdec = wdec;
  assign nv_code[0] = nv_code_one_i;
  assign nv_code[1] = nv_code_two_i;

  // A refused write must leave every setting register and timer untouched; it only sets rej_r
  assign wr_hit = wr_en_i && wdec[1];
  assign wr_ok = wr_hit && unlock_i; // RL3
  assign wr_idx = wdec[0];
  assign rd_idx = rdec[0];
  // Either trigger bit moves both converters at once
  assign apply_any = go_i || apply_with_disable_bit_i; // RL5

  // Register image: host writes and nonvolatile load
  always_comb begin
    pfm_nxt = pfm_r;
    shadow_nxt = shadow_r;
    blank_start = '0;
    rej_nxt = 1'b0;
    if (nv_load_i) begin
      // Load first, so a host write in the same cycle wins
      for (int i = 0; i < N; i++) begin
        shadow_nxt[i] = nv_code[i]; // RL9
      end
    end
    if (wr_ok) begin
      pfm_nxt[wr_idx] = wdata_i[bvsr_pkg::PFM_BIT]; // RL6
      shadow_nxt[wr_idx] = wdata_i[bvsr_pkg::CODE_MSB:0]; // RL9
      blank_start[wr_idx] = 1'b1; // RL4
    end else if (wr_hit) begin
      rej_nxt = 1'b1; // RL3
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pfm_r <= {N{bvsr_pkg::PFM_RESET}}; // RL6
      for (int i = 0; i < N; i++) begin
        shadow_r[i] <= bvsr_pkg::CODE_RESET; // RL7
      end
      rej_r <= 1'b0;
    end else begin
      pfm_r <= pfm_nxt;
      shadow_r <= shadow_nxt;
      rej_r <= rej_nxt;
    end
  end

  // Converter settings: only a load or a trigger moves them, never a bare write
  always_comb begin
    active_nxt = active_r;
    adis_nxt = 1'b0;
    if (nv_load_i) begin
      for (int i = 0; i < N; i++) begin
        active_nxt[i] = nv_code[i]; // RL9
      end
    end
    // Trigger in the same cycle as a write applies the freshly written code
    if (apply_any) begin
      for (int i = 0; i < N; i++) begin
        active_nxt[i] = shadow_nxt[i]; // RL5
      end
      adis_nxt = apply_with_disable_bit_i;
    end
    for (int i = 0; i < N; i++) begin
      mv_nxt[i] = code_to_mv(active_nxt[i]); // RL7
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < N; i++) begin
        active_r[i] <= bvsr_pkg::CODE_RESET; // RL7
        mv_r[i] <= MV_RESET;
      end
      adis_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      mv_r <= mv_nxt;
      adis_r <= adis_nxt;
    end
  end

  // Read path; readback shows the shadow, reserved bit forced low
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = rd_en_i;
    if (rd_en_i) begin
      rdata_nxt = '0;
      if (rdec[1]) begin
        rdata_nxt[bvsr_pkg::PFM_BIT] = pfm_r[rd_idx];
        rdata_nxt[bvsr_pkg::RSVD_BIT] = 1'b0; // RL6
        rdata_nxt[bvsr_pkg::CODE_MSB:0] = shadow_r[rd_idx];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // One blanking window per converter
  bvsr_blank_timer #(.CYCLES(BLANK_CYCLES)) u_blank_one (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(blank_start[0]),
    .blank_o(buck_converter_one_blank_o)
  );
  bvsr_blank_timer #(.CYCLES(BLANK_CYCLES)) u_blank_two (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(blank_start[1]),
    .blank_o(buck_converter_two_blank_o)
  );

  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign wr_rejected_o = rej_r;
  assign apply_disable_o = adis_r;
  assign buck_converter_one_code_o = active_r[0];
  assign buck_converter_two_code_o = active_r[1];
  assign buck_converter_one_mv_o = mv_r[0];
  assign buck_converter_two_mv_o = mv_r[1];
  assign buck_converter_one_pfm_o = pfm_r[0];
  assign buck_converter_two_pfm_o = pfm_r[1];
endmodule

// ---- test/bvsr_host.sv ----
// Host model: drives register port and control strobes.
// Assumes bench calls its tasks; every change lands at a falling edge.
`timescale 1ns/1ps
module bvsr_host (
  input wire logic clk_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic unlock_o,
  output logic go_o,
  output logic apply_o
);
  // Idle bus shows inverted data so a stale value never looks valid
  initial begin
    {wr_en_o, rd_en_o, unlock_o, go_o, apply_o} = 5'h00;
    addr_o = 8'hff;
    wdata_o = 8'h00;
  end
  task wr(input logic [7:0] a, input logic [7:0] d, input logic ul);
    @(negedge clk_i);
    {unlock_o, wr_en_o, addr_o, wdata_o} = {ul, 1'h1, a, d};
    @(negedge clk_i);
    {unlock_o, wr_en_o, addr_o, wdata_o} = {2'h0, ~a, ~d};
  endtask
  task rd(input logic [7:0] a);
    @(negedge clk_i);
    {rd_en_o, addr_o} = {1'h1, a};
    @(negedge clk_i);
    {rd_en_o, addr_o} = {1'h0, ~a};
  endtask
  // One-cycle trigger in the control register
  task apply(input logic dis);
    @(negedge clk_i);
    {go_o, apply_o} = {~dis, dis};
    @(negedge clk_i);
    {go_o, apply_o} = 2'h0;
  endtask
endmodule

// ---- test/bvsr_regs_checker.sv ----
// Concurrent checks on the setting-register ports.
// Assumes one clock domain and the sync reset of the block.
`timescale 1ns/1ps
module bvsr_regs_checker (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic unlock_i,
  input wire logic go_i,
  input wire logic apply_with_disable_bit_i,
  input wire logic nv_load_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic wr_rejected_o,
  input wire logic apply_disable_o,
  input wire logic [5:0] buck_converter_one_code_o,
  input wire logic [10:0] buck_converter_one_mv_o,
  input wire logic buck_converter_one_blank_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Write request steps
  sequence s_wr_one;
    wr_en_i && unlock_i && addr_i == 8'h16;
  endsequence
  sequence s_wr_locked;
    wr_en_i && !unlock_i && (addr_i == 8'h16 || addr_i == 8'h17);
  endsequence
  AST_RD_ANSWER: assert property (rd_en_i |=> rvalid_o) else $error("read not answered");
  AST_RD_QUIET: assert property (!rd_en_i |=> !rvalid_o) else $error("spurious rvalid");
  AST_LOCKED: assert property (s_wr_locked |=> wr_rejected_o) else $error("no reject");
  AST_BLANK: assert property (s_wr_one |=> buck_converter_one_blank_o [*8])
    else $error("blanking missing after write");
  AST_RSVD: assert property (rvalid_o |-> !rdata_o[6]) else $error("reserved bit set");
  AST_HOLD: assert property (!go_i && !apply_with_disable_bit_i && !nv_load_i |=>
    $stable(buck_converter_one_code_o)) else $error("code changed without trigger");
  AST_NOTE: assert property (apply_with_disable_bit_i |=> apply_disable_o)
    else $error("apply notice missing");
  AST_MV_FINE: assert property (buck_converter_one_code_o <= 6'h32 |->
    buck_converter_one_mv_o == 11'h352 + 11'(buck_converter_one_code_o) * 11'h00a)
    else $error("fine step mv wrong");
  AST_MV_COARSE: assert property (buck_converter_one_code_o > 6'h32 |->
    buck_converter_one_mv_o == 11'h546 + 11'(buck_converter_one_code_o - 6'h32) * 11'h019)
    else $error("coarse step mv wrong");
endmodule
bind bvsr_regs bvsr_regs_checker u_chk (.clk_i, .srst_i, .wr_en_i, .rd_en_i, .addr_i,
  .unlock_i, .go_i, .apply_with_disable_bit_i, .nv_load_i, .rdata_o, .rvalid_o,
  .wr_rejected_o, .apply_disable_o, .buck_converter_one_code_o, .buck_converter_one_mv_o,
  .buck_converter_one_blank_o);

// ---- test/bvsr_regs_tb_top.sv ----
// Self-checking bench for the buck setting registers.
// Assumes host model drives the port; blanking shortened to 20 cycles.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module bvsr_regs_tb_top;
  logic clk_i = 1'h0;
  logic srst_i = 1'h1;
  logic wr, rd, ul, go, apl, nvl = 1'h0;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] nv1 = 6'h00, nv2 = 6'h05, c1, c2;
  logic [10:0] mv1, mv2;
  logic rv, rej, apd, p1, p2, b1, b2;
  int err_count = 0, check_count = 0, n;
  bvsr_host u_host (.clk_i(clk_i), .wr_en_o(wr), .rd_en_o(rd), .addr_o(addr),
    .wdata_o(wdata), .unlock_o(ul), .go_o(go), .apply_o(apl));
  bvsr_regs #(.BLANK_CYCLES(20)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .wr_en_i(wr),
    .rd_en_i(rd), .addr_i(addr), .wdata_i(wdata), .unlock_i(ul), .go_i(go),
    .apply_with_disable_bit_i(apl), .nv_load_i(nvl), .nv_code_one_i(nv1),
    .nv_code_two_i(nv2), .rdata_o(rdata), .rvalid_o(rv), .wr_rejected_o(rej),
    .apply_disable_o(apd), .buck_converter_one_code_o(c1), .buck_converter_two_code_o(c2),
    .buck_converter_one_mv_o(mv1), .buck_converter_two_mv_o(mv2),
    .buck_converter_one_pfm_o(p1), .buck_converter_two_pfm_o(p2),
    .buck_converter_one_blank_o(b1), .buck_converter_two_blank_o(b2));
  initial forever #20 clk_i = ~clk_i;
  task tally_and_finish;
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Read answer stands one cycle, so it is sampled at once
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a);
    `CHK("rvalid", 1'h1, rv)
    `CHK("rdata", e, rdata)
  endtask
  task t_reset;
    rdchk(8'h16, 8'h99);
    rdchk(8'h17, 8'h99);
    rdchk(8'h18, 8'h00);
    `CHK("code_two", 6'h19, c2)
    `CHK("mv_one", 11'h44c, mv1)
    `CHK("pfm_two", 1'h1, p2)
  endtask
  task t_locked;
    u_host.wr(8'h16, 8'h05, 1'h0);
    `CHK("rejected", 1'h1, rej)
    `CHK("blank_one", 1'h0, b1)
    rdchk(8'h16, 8'h99);
  endtask
  // Reserved bit written high must read back low
  task t_write_apply;
    u_host.wr(8'h16, 8'h7f, 1'h1);
    `CHK("rejected", 1'h0, rej)
    `CHK("blank_one", 1'h1, b1)
    rdchk(8'h16, 8'h3f);
    `CHK("code_one", 6'h19, c1)
    u_host.apply(1'h0);
    `CHK("code_one", 6'h3f, c1)
    `CHK("mv_one", 11'h68b, mv1)
    `CHK("pfm_one", 1'h0, p1)
    `CHK("apply_note", 1'h0, apd)
    `CHK("code_two", 6'h19, c2)
    u_host.wr(8'h17, 8'h33, 1'h1);
    `CHK("pfm_two", 1'h0, p2)
    u_host.apply(1'h1);
    `CHK("apply_note", 1'h1, apd)
    `CHK("mv_two", 11'h55f, mv2)
  endtask
  // Write lands mid-blank, so this also proves retrigger
  task t_blank;
    u_host.wr(8'h17, 8'h99, 1'h1);
    n = 0;
    while (b2 === 1'h1 && n < 100) begin
      n++;
      @(negedge clk_i);
    end
    `CHK("blank_cycles", 20, n)
  endtask
  task t_nv;
    @(negedge clk_i) nvl = 1'h1;
    @(negedge clk_i) nvl = 1'h0;
    `CHK("code_one", 6'h00, c1)
    `CHK("mv_one", 11'h352, mv1)
    rdchk(8'h17, 8'h85);
  endtask
  // Reset mid-run must restore converter one's fields that writes and loads moved
  task t_midreset;
    @(negedge clk_i) srst_i = 1'h1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'h0;
    `CHK("code_one", 6'h19, c1)
    `CHK("mv_one", 11'h44c, mv1)
    `CHK("pfm_one", 1'h1, p1)
    `CHK("blank_one", 1'h0, b1)
    rdchk(8'h16, 8'h99);
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    srst_i = 1'h0;
    t_reset;
    t_locked;
    t_write_apply;
    t_blank;
    t_nv;
    t_midreset;
    tally_and_finish;
  end
  // Watchdog well beyond the roughly 65 cycles the tests need
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    tally_and_finish;
  end
endmodule
